// File: bench/dc_balanced_lane_deserializer_tb_top.sv
// Purpose: self-checking bench of the lane deserializer
// Assumes: 20 lock periods, slow limit 200 cycles, rising and falling strobe variants
// Notes: words are held several frames so each one is seen settled
`timescale 1ns/1ps
module dc_balanced_lane_deserializer_tb_top;
  import deser_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic power_down_n = 1'b0;
  logic link_en = 1'b0;
  par_word_t tx_word = '0;
  logic link_clk;
  logic [2:0] lane;
  par_word_t dout;
  logic data_oe_n;
  logic strobe;
  logic strobe_oe_n;
  par_word_t dout_f;
  logic strobe_f;
  int err_total = 0;
  int total_checks = 0;
  par_word_t words [8] = '{21'h1FFFFF, 21'h00007F, 21'h003F80, 21'h1FC000,
                           21'h155555, 21'h000000, 21'h0A5A5A, 21'h1FFFFE};

  always #5 ref_clk = ~ref_clk;

  lane_serializer_model partner (
    .ref_clk(ref_clk),
    .en(link_en),
    .word(tx_word),
    .link_clk(link_clk),
    .lane(lane)
  );

  dc_balanced_lane_deserializer #(.LOCK_PERIODS(20), .SLOW_LIMIT(200), .RISING_STROBE(1'b1)) uut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .forwarded_link_clock_in(link_clk),
    .serial_lane0_in_p(lane[0]),
    .serial_lane1_in_p(lane[1]),
    .serial_lane2_in_p(lane[2]),
    .power_down_n(power_down_n),
    .parallel_data_out(dout),
    .parallel_data_oe_n(data_oe_n),
    .parallel_strobe_clock_out(strobe),
    .strobe_clock_oe_n(strobe_oe_n)
  );

  // falling-edge strobe variant on the same link
  dc_balanced_lane_deserializer #(.LOCK_PERIODS(20), .SLOW_LIMIT(200), .RISING_STROBE(1'b0)) uut_fall (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .forwarded_link_clock_in(link_clk),
    .serial_lane0_in_p(lane[0]),
    .serial_lane1_in_p(lane[1]),
    .serial_lane2_in_p(lane[2]),
    .power_down_n(power_down_n),
    .parallel_data_out(dout_f),
    .parallel_data_oe_n(),
    .parallel_strobe_clock_out(strobe_f),
    .strobe_clock_oe_n()
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_word(input par_word_t exp);
    int i;
    for (i = 0; i < 3000; i++) begin
      if (dout === exp) break;
      cyc(1);
    end
    check(dout, exp);
    // a word that never arrived ends the run here
    if (i == 3000) begin
      give_verdict();
    end
  endtask

  task automatic t_lock();
    tx_word = 21'h1FFFFF;
    link_en = 1'b1;
    power_down_n = 1'b1;
    cyc(6);
    check({data_oe_n, strobe_oe_n}, 2'h0);
    for (int f = 0; f < 15; f++) begin
      check(dout, 21'h000000);
      cyc(90);
    end
    wait_word(21'h1FFFFF);
    $display("lock test done");
  endtask

  task automatic t_words();
    foreach (words[k]) begin
      tx_word = words[k];
      wait_word(words[k]);
      cyc(180);
      check(dout, words[k]);
    end
    $display("word test done");
  endtask

  task automatic t_strobe();
    int rises = 0;
    logic prev;
    prev = strobe;
    repeat (900) begin
      cyc(1);
      if (strobe === 1'b1 && prev === 1'b0) begin
        rises++;
        check(link_clk, 1'b0);
        check(strobe_f, 1'b0);
      end
      prev = strobe;
    end
    check(rises, 10);
    check(dout_f, 21'h1FFFFE);
    check(strobe_oe_n, 1'b0);
    $display("strobe test done");
  endtask

  task automatic t_stop();
    link_en = 1'b0;
    cyc(400);
    check(dout, 21'h000000);
    check(data_oe_n, 1'b0);
    tx_word = 21'h0A5A5A;
    link_en = 1'b1;
    cyc(90);
    check(dout, 21'h000000);
    wait_word(21'h0A5A5A);
    $display("stop test done");
  endtask

  task automatic t_powerdown();
    power_down_n = 1'b0;
    cyc(4);
    check({data_oe_n, strobe_oe_n}, 2'h3);
    $display("power-down test done");
  endtask

  initial begin
    cyc(6);
    rst_b = 1'b1;
    cyc(4);
    check({data_oe_n, strobe_oe_n}, 2'h3);
    t_lock();
    t_words();
    t_strobe();
    t_stop();
    t_powerdown();
    give_verdict();
  end
endmodule

// File: bench/lane_serializer_model.sv
// Purpose: far-end serializer for the three data lanes and the forwarded clock
// Assumes: 90 ref_clk cycles per word, 10 per bit
// Notes: clock stands low between frames; idle lanes toggle
`timescale 1ns/1ps
module lane_serializer_model (
  // clock
  input wire logic ref_clk,
  // word source
  input wire logic en,
  input wire logic [20:0] word,
  // link pins
  output logic link_clk,
  output logic [2:0] lane
);
  int cyc = 0;
  int hi_len = 40;
  int sum [3] = '{0, 0, 0};
  logic act = 1'b0;
  logic long_hi = 1'b0;
  logic [8:0] frm [3];
  initial link_clk = 1'b0;
  initial lane = 3'h0;
  always @(posedge ref_clk) begin : drive
    logic [6:0] pay;
    int d;
    if (cyc == 0) begin
      act = en;
    end
    // the running sum only follows frames that are really sent
    if (cyc == 0 && act) begin
      for (int l = 0; l < 3; l++) begin
        pay = word[7*l +: 7];
        d = 2 * $countones(pay) - 7;
        // invert when it would push the sum further from zero
        if ((sum[l] > 0 && d > 0) || (sum[l] < 0 && d < 0)) begin
          frm[l] = {2'b01, ~pay};
        end else begin
          frm[l] = {2'b10, pay};
        end
        sum[l] += 2 * $countones(frm[l]) - 9;
      end
      hi_len = long_hi ? 50 : 40;
      long_hi = !long_hi;
    end
    if (act) begin
      link_clk <= (cyc < hi_len);
      for (int l = 0; l < 3; l++) begin
        lane[l] <= frm[l][cyc / 10];
      end
      cyc = (cyc == 89) ? 0 : cyc + 1;
    end else begin
      link_clk <= 1'b0;
      lane <= ~lane;
    end
  end
endmodule

// File: core/dc_balanced_lane_deserializer.sv
// Purpose: receive logic of a three-lane DC-balanced link, nine bits per lane word
// Assumes: ref_clk oversamples the lanes; link clock and lanes arrive unrelated to ref_clk
// Notes: bit timing is recovered from the measured link clock period
// Behaviour
// RULE1: lane 0 feeds outputs 0-6, lane 1 outputs 7-13, lane 2 outputs 14-20.
// RULE2: payload of seven bits is re-inverted when the indicator pair marks inversion.
// RULE3: far end inverts or keeps each word by the sign of its running sum.
// RULE4: far end keeps the data lane running sum spread within 10.
// RULE5: far end keeps the clock lane running sum spread within five.
// RULE6: far end alternates link clock high time between 4/9 and 5/9.
// RULE7: power-down low puts data outputs and output clock in high impedance.
// RULE8: output clock runs at word rate; strobe edge chosen per variant.
// RULE9: link clock rate range is honoured; slower clocks count as stopped.
// RULE10: after power-down release outputs stay low for 32,800 link periods of lock.
// RULE11: stopped or too slow link clock drives all parallel outputs low.
// RULE12: each lane carries nine bits per link clock period.
// RULE13: link clock rising edge starts bit 0; bits 7 and 8 are indicators.
`timescale 1ns/1ps
`include "deser_map.svh"
module dc_balanced_lane_deserializer import deser_pkg::*; #(
  parameter int unsigned LOCK_PERIODS = `LOCK_PERIODS,
  parameter int unsigned SLOW_LIMIT = `SLOW_LIMIT_CYC,
  parameter bit RISING_STROBE = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link pins
  input wire logic forwarded_link_clock_in,
  input wire logic serial_lane0_in_p,
  input wire logic serial_lane1_in_p,
  input wire logic serial_lane2_in_p,
  input wire logic power_down_n,
  // parallel side
  output logic [`PAR_BITS-1:0] parallel_data_out,
  output logic parallel_data_oe_n,
  output logic parallel_strobe_clock_out,
  output logic strobe_clock_oe_n
);
  logic [`LANES-1:0] lane_meta_q;
  logic [`LANES-1:0] lane_sync_q;
  logic link_meta_q;
  logic link_sync_q;
  logic link_prev_q;
  logic pd_meta_q;
  logic pd_sync_q;
  logic [`CNT_BITS-1:0] per_cnt_q;
  logic [`CNT_BITS-1:0] period_q;
  logic [`PHASE_BITS-1:0] acc_q;
  logic [`PHASE_BITS-1:0] thr_q;
  logic [3:0] bit_idx_q;
  logic word_done_q;
  lane_frame_t frame_q [`LANES];
  logic [`LANES-1:0] inv;
  par_word_t decoded;
  logic push_valid_q;
  par_word_t push_data_q;
  par_word_t data_q;
  logic strobe_q;
  state_t state_q;
  state_t state_d;
  logic [`CNT_BITS-1:0] lock_cnt_q;

  word_stream_if #(.W(`PAR_BITS)) push_s ();
  word_stream_if #(.W(`PAR_BITS)) pop_s ();

  // pins cross into ref_clk through two flops each
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_meta_q <= '0;
      lane_sync_q <= '0;
      {link_meta_q, link_sync_q, link_prev_q} <= 3'h0;
      {pd_meta_q, pd_sync_q} <= 2'h0;
    end else begin
      lane_meta_q <= {serial_lane2_in_p, serial_lane1_in_p, serial_lane0_in_p};
      lane_sync_q <= lane_meta_q;
      {link_meta_q, link_sync_q, link_prev_q} <= {forwarded_link_clock_in, link_meta_q, link_sync_q};
      {pd_meta_q, pd_sync_q} <= {power_down_n, pd_meta_q};
    end
  end

  wire link_rise = link_sync_q & ~link_prev_q;
  wire slow = (per_cnt_q >= `CNT_BITS'(SLOW_LIMIT)); // RULE9 RULE11
  wire run = (state_q == ST_RUN);
  wire [`CNT_BITS-1:0] per_cnt_inc = (per_cnt_q == 16'hFFFF) ? per_cnt_q : per_cnt_q + 16'h1;

  // link period in ref_clk cycles, measured rise to rise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_q <= '0;
      period_q <= '0;
    end else begin
      per_cnt_q <= link_rise ? '0 : per_cnt_inc;
      if (link_rise) begin
        period_q <= per_cnt_inc;
      end
    end
  end

  // bit k is sampled once acc reaches (2k+1)*period, the middle of bit k
  wire sample_fire = (bit_idx_q < 4'(`BITS_PER_WORD)) && (acc_q >= thr_q); // RULE12
  wire word_done = sample_fire && (bit_idx_q == 4'(`BITS_PER_WORD - 1));
  wire [`PHASE_BITS-1:0] period_ext = `PHASE_BITS'(period_q);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= '0;
      thr_q <= '0;
      bit_idx_q <= 4'h0;
      word_done_q <= 1'b0;
    end else begin
      word_done_q <= word_done;
      if (link_rise) begin
        acc_q <= `PHASE_BITS'(`PHASE_STEP); // RULE13
        thr_q <= period_ext;
        bit_idx_q <= 4'h0;
      end else begin
        acc_q <= acc_q + `PHASE_BITS'(`PHASE_STEP);
        if (sample_fire) begin
          thr_q <= thr_q + (period_ext << 1);
          bit_idx_q <= bit_idx_q + 4'h1;
        end
      end
    end
  end

  for (genvar i = 0; i < `LANES; i++) begin : g_lane
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        frame_q[i] <= '0;
      end else if (sample_fire) begin
        frame_q[i][bit_idx_q] <= lane_sync_q[i];
      end
    end
    assign inv[i] = frame_q[i][`INV_FLAG_POS] & ~frame_q[i][`INV_COMP_POS]; // RULE13
    assign decoded[i*`PAYLOAD_BITS +: `PAYLOAD_BITS] =
      frame_q[i][`PAYLOAD_BITS-1:0] ^ {`PAYLOAD_BITS{inv[i]}}; // RULE1 RULE2
  end

  // a word waits here while the FIFO is full; the next word is then dropped
  wire push_blocked = push_valid_q && !push_s.ready;
  assign push_s.valid = push_valid_q;
  assign push_s.data = push_data_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      push_valid_q <= 1'b0;
      push_data_q <= '0;
    end else if (!run) begin
      push_valid_q <= 1'b0;
    end else if (word_done_q && !push_blocked) begin
      push_valid_q <= 1'b1;
      push_data_q <= decoded;
    end else if (push_s.ready) begin
      push_valid_q <= 1'b0;
    end
  end

  word_fifo #(.WIDTH(`PAR_BITS), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(!run),
    .in_s(push_s.snk),
    .out_s(pop_s.src)
  );

  // one word leaves per link period, on the link rise
  assign pop_s.ready = run && link_rise;
  wire pop = pop_s.valid && pop_s.ready;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      data_q <= !run ? '0 : (pop ? pop_s.data : data_q); // RULE10 RULE11
      strobe_q <= run & (link_sync_q ^ RISING_STROBE); // RULE8
    end
  end

  assign parallel_data_out = data_q;
  assign parallel_strobe_clock_out = strobe_q;
  assign parallel_data_oe_n = (state_q == ST_OFF); // RULE7
  assign strobe_clock_oe_n = (state_q == ST_OFF); // RULE7

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (pd_sync_q) state_d = ST_LOCK;
      end
      ST_LOCK: begin
        if (!pd_sync_q) state_d = ST_OFF;
        else if (link_rise && !slow && lock_cnt_q == `CNT_BITS'(LOCK_PERIODS - 1)) state_d = ST_RUN; // RULE10
      end
      ST_RUN: begin
        if (!pd_sync_q) state_d = ST_OFF; // RULE7
        else if (slow) state_d = ST_LOCK; // RULE11
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_OFF;
      lock_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_LOCK || slow) begin
        lock_cnt_q <= '0;
      end else if (link_rise) begin
        lock_cnt_q <= lock_cnt_q + 16'h1; // RULE10
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence lock_exit_s;
    state_q == ST_LOCK ##1 state_q == ST_RUN;
  endsequence

  sequence slow_hit_s;
    run && slow;
  endsequence

  wire push_takes = word_done_q && run && !push_blocked;

  pd_hiz_a: assert property ( // RULE7
    !pd_sync_q |=> parallel_data_oe_n && strobe_clock_oe_n
  ) else $error("outputs driven while powered down");

  low_in_lock_a: assert property ( // RULE10
    !run |=> parallel_data_out == '0 && !parallel_strobe_clock_out
  ) else $error("outputs not low before lock");

  lock_length_a: assert property ( // RULE10
    lock_exit_s |-> $past(lock_cnt_q, 1) == `CNT_BITS'(LOCK_PERIODS - 1) && $past(link_rise, 1)
  ) else $error("lock left after wrong period count");

  // power-down in the same cycle takes priority and sends the block off instead
  slow_drop_a: assert property ( // RULE11
    slow_hit_s |=> state_q == ($past(pd_sync_q) ? ST_LOCK : ST_OFF) ##1 parallel_data_out == '0
  ) else $error("slow link clock did not force outputs low");

  // expected payload is rebuilt from the raw indicator bits, not from the decode wires
  invert_lane0_a: assert property ( // RULE2
    push_takes |=> push_s.data[6:0] ==
      ($past(frame_q[0][`INV_FLAG_POS] && !frame_q[0][`INV_COMP_POS]) ?
        ~$past(frame_q[0][6:0]) : $past(frame_q[0][6:0]))
  ) else $error("lane 0 payload decoded wrongly");

  lane_map_a: assert property ( // RULE1
    push_takes |=> push_s.data[13:7] ==
      ($past(frame_q[1][`INV_FLAG_POS] && !frame_q[1][`INV_COMP_POS]) ?
        ~$past(frame_q[1][6:0]) : $past(frame_q[1][6:0]))
      && push_s.data[20:14] ==
      ($past(frame_q[2][`INV_FLAG_POS] && !frame_q[2][`INV_COMP_POS]) ?
        ~$past(frame_q[2][6:0]) : $past(frame_q[2][6:0]))
  ) else $error("lanes 1 or 2 mapped wrongly");

  strobe_edge_a: assert property ( // RULE8
    run && $past(run) && $changed(parallel_data_out) |-> parallel_strobe_clock_out == !RISING_STROBE
  ) else $error("data changed at the active strobe level");

  nine_bits_a: assert property ( // RULE12
    word_done |-> ##1 bit_idx_q == 4'(`BITS_PER_WORD) && !sample_fire
  ) else $error("word closed without nine samples");
endmodule

// File: core/word_fifo.sv
// Purpose: word buffer between the lane decoder and the parallel output stage
// Assumes: DEPTH is a power of two
// Notes: clear empties it at once; storage has no reset
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clear,
  // fill and drain sides
  word_stream_if.snk in_s,
  word_stream_if.src out_s
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_s.valid && !full;
  wire pop = out_s.ready && !empty;

  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clear) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_s.data;
    end
  end
endmodule

// File: pkg/deser_map.svh
// Purpose: offsets, field positions and timing counts of the lane deserializer
// Assumes: ref_clk at 100 MHz
// Notes: definitions only
`ifndef DESER_MAP_SVH
`define DESER_MAP_SVH

`define LANES 3
`define BITS_PER_WORD 9
`define PAYLOAD_BITS 7
`define PAR_BITS 21
`define INV_FLAG_POS 7
`define INV_COMP_POS 8
`define PHASE_STEP 18
`define FIFO_DEPTH 8
`define CNT_BITS 16
`define PHASE_BITS 22

`define CLK_PERIOD_NS 10
`define LINK_MAX_PERIOD_NS 125
`define SLOW_LIMIT_CYC ((`LINK_MAX_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_PERIODS 32800

`endif

// File: pkg/deser_pkg.sv
// Purpose: types shared by the lane deserializer
// Assumes: deser_map.svh holds the numbers
// Notes: none
package deser_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_LOCK = 2'h1,
    ST_RUN = 2'h3
  } state_t;
  typedef logic [20:0] par_word_t;
  typedef logic [8:0] lane_frame_t;
endpackage

// File: pkg/word_stream_if.sv
// Purpose: valid/ready word channel between the deserializer and its FIFO
// Assumes: one clock shared by both ends
// Notes: a word moves on a cycle with valid and ready both high
`timescale 1ns/1ps
interface word_stream_if #(parameter int unsigned W = 21);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
